// ==== rtl/idws_defines.svh ====
`ifndef IDWS_DEFINES_SVH
`define IDWS_DEFINES_SVH
// Operation
// - Code is unsigned, 0 to 4095 of 4096
// - Converter end only receives, never initiates
// - Rates of 100k, 400k, 3.4M bit/s
// - Ignore ten-bit and general call addresses
// - SDA falling with SCL high starts transfer
// - First byte: seven address bits, write bit
// - Addressed slave pulls SDA low ninth clock
// - Nine clocks per byte, MSB first, ack
// - SDA changes only while SCL is low
// - Master ends with stop after last ack
// - Address 100110, select bit, write zero
// - High byte: 00, mode bits, code 11:8
// - Update at falling edge of low ack
// - Modes: normal, 1k, 100k, high impedance

// ==========================================================
// Clock, rates and derived quarter-bit counts
// ==========================================================
`define IDWS_CLK_KHZ 40000
`define IDWS_RATE_STD_KBPS 100
`define IDWS_RATE_FAST_KBPS 400
`define IDWS_RATE_HS_KBPS 3400
`define IDWS_QTR(r) ((`IDWS_CLK_KHZ + 4 * (r) - 1) / (4 * (r)))
`define IDWS_QTR_STD `IDWS_QTR(`IDWS_RATE_STD_KBPS)
`define IDWS_QTR_FAST `IDWS_QTR(`IDWS_RATE_FAST_KBPS)
`define IDWS_QTR_HS `IDWS_QTR(`IDWS_RATE_HS_KBPS)
`define IDWS_QTR_W 9

// ==========================================================
// Link bytes and fields
// ==========================================================
`define IDWS_ADDR_PRESET 6'b100110
`define IDWS_MASTER_CODE 8'h08
`define IDWS_ACK_BIT 4'h8
`define IDWS_ACK_CLK 4'h9
`define IDWS_CODE_RESET 12'h000
`define IDWS_MODE_RESET 2'h0

// ==========================================================
// Host register map and fields
// ==========================================================
`define IDWS_REG_CTRL 8'h00
`define IDWS_REG_WORD 8'h04
`define IDWS_REG_STATUS 8'h08
`define IDWS_CTRL_GO 0
`define IDWS_CTRL_KEEP 1
`define IDWS_CTRL_RATE_LO 2
`define IDWS_CTRL_SEL 4
`define IDWS_RATE_STD 2'h0
`define IDWS_RATE_FAST 2'h1
`define IDWS_RATE_HS 2'h2
`endif

// ==== rtl/idws_dev.sv ====
`timescale 1ns/100ps
`include "idws_defines.svh"
// ==========================================================
// Converter end: write-only two-wire slave
// ==========================================================
module idws_dev
    import idws_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    idws_if.dev LINK,
    input wire logic DEVICE_SELECT_PIN,
    output logic [11:0] CONVERTER_CODE,
    output logic [1:0] POWER_DOWN_MODE,
    output logic CODE_UPDATED,
    output logic ADDRESSED
);
    idws_dev_state_e state;
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic sel_m;
    logic sel_s;
    logic [1:0] strap_wait;
    logic sel_taken;
    logic device_select_pin;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] control_high_byte;
    logic ack_drive;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic addr_match;

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    // Both wires share the same delay, so their order is kept.
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_m <= LINK.scl;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= LINK.sda;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    // Select strap passes two flip-flops too.
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            sel_m <= 1'b0;
            sel_s <= 1'b0;
        end
        else
        begin
            sel_m <= DEVICE_SELECT_PIN;
            sel_s <= sel_m;
        end
    end

    // ==========================================================
    // Strap capture after reset release
    // ==========================================================
    // The pin is taken once, after the synchroniser has filled.
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            strap_wait <= 2'h0;
            sel_taken <= 1'b0;
            device_select_pin <= 1'b0;
        end
        else if (!sel_taken)
        begin
            strap_wait <= strap_wait + 2'h1;
            if (strap_wait == 2'h3)
            begin
                sel_taken <= 1'b1;
                device_select_pin <= sel_s;
            end
        end
    end

    // ==========================================================
    // Line events
    // ==========================================================
    // Only the second and third stages are compared.
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;

    // Ten-bit headers and general call fail this compare.
    assign addr_match = (shift[7:2] == `IDWS_ADDR_PRESET)
        && (shift[1] == device_select_pin)
        && !shift[0];

    // ==========================================================
    // Receive sequencer
    // ==========================================================
    // Data is sampled only on SCL rise, so SDA moving while SCL
    // is high is seen as start or stop, never as data.
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            state <= DS_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            control_high_byte <= 8'h00;
            ack_drive <= 1'b0;
        end
        else if (start_seen)
        begin
            state <= DS_ADDR;
            bit_cnt <= 4'h0;
            ack_drive <= 1'b0;
        end
        else if (stop_seen)
        begin
            state <= DS_IDLE;
            bit_cnt <= 4'h0;
            ack_drive <= 1'b0;
        end
        else if (state != DS_IDLE)
        begin
            if (scl_rise)
            begin
                if (bit_cnt < `IDWS_ACK_BIT)
                begin
                    shift <= {shift[6:0], sda_s};
                end
                bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == `IDWS_ACK_BIT)
            begin
                // Acknowledge goes on while SCL is low.
                if (state == DS_ADDR && !addr_match)
                begin
                    // Master code and foreign addresses stay unacked,
                    // and the end waits for the next start.
                    state <= DS_IDLE;
                end
                else
                begin
                    ack_drive <= 1'b1;
                end
            end
            else if (scl_fall && bit_cnt == `IDWS_ACK_CLK)
            begin
                ack_drive <= 1'b0;
                bit_cnt <= 4'h0;
                if (state == DS_ADDR)
                begin
                    state <= DS_HIGH;
                end
                else if (state == DS_HIGH)
                begin
                    control_high_byte <= shift;
                    state <= DS_LOW;
                end
                else
                begin
                    state <= DS_HIGH;
                end
            end
        end
    end

    // ==========================================================
    // Converter register
    // ==========================================================
    // Loaded at the end of the low byte's acknowledge only, so a
    // word cut short by start or stop leaves the output alone.
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            CONVERTER_CODE <= `IDWS_CODE_RESET;
            POWER_DOWN_MODE <= `IDWS_MODE_RESET;
            CODE_UPDATED <= 1'b0;
        end
        else if (!start_seen && !stop_seen && state == DS_LOW
            && scl_fall && bit_cnt == `IDWS_ACK_CLK)
        begin
            // Mode and code are loaded together. The two top bits are
            // expected zero and are not checked.
            CONVERTER_CODE <= {control_high_byte[3:0], shift};
            POWER_DOWN_MODE <= control_high_byte[5:4];
            CODE_UPDATED <= 1'b1;
        end
        else
        begin
            CODE_UPDATED <= 1'b0;
        end
    end

    // ==========================================================
    // Pin drive and status
    // ==========================================================
    // Only the acknowledge is ever driven; this end never makes
    // SCL or a start of its own.
    assign LINK.dev_sda_o = 1'b0;
    assign LINK.dev_sda_oe_n = ~ack_drive;
    assign ADDRESSED = (state == DS_HIGH) || (state == DS_LOW);
endmodule : idws_dev

// ==== rtl/idws_host.sv ====
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "idws_defines.svh"
// ==========================================================
// Host end: APB-controlled two-wire write master
// ==========================================================
module idws_host
    import idws_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    idws_if.host LINK
);
    idws_host_state_e state;
    idws_byte_e byte_idx;
    logic keep_open;
    logic [1:0] rate;
    logic target_sel;
    logic [13:0] word;
    logic nack;
    logic hs_active;
    logic go;
    logic [`IDWS_QTR_W-1:0] qcnt;
    logic [`IDWS_QTR_W-1:0] qlimit;
    logic tick;
    logic [1:0] phase;
    logic [3:0] bit_cnt;
    logic [7:0] tx;
    logic sda_m;
    logic sda_s;
    logic scl_oe_n;
    logic sda_oe_n;
    logic wr;
    logic rd_setup;
    logic busy;

    // Returns the byte to send for a sequence slot.
    function automatic logic [7:0] byte_of(input idws_byte_e b,
        input logic s, input logic [13:0] w);
        if (b == HB_MCODE)
            byte_of = `IDWS_MASTER_CODE;
        else if (b == HB_ADDR)
            byte_of = {`IDWS_ADDR_PRESET, s, 1'b0};
        else if (b == HB_HIGH)
            byte_of = {2'b00, w[13:12], w[11:8]};
        else
            byte_of = w[7:0];
    endfunction : byte_of

    // ==========================================================
    // APB slave, zero wait states
    // ==========================================================
    assign PREADY = 1'b1;
    assign wr = PSEL & PENABLE & PWRITE;
    assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
    assign busy = (state != HS_IDLE) && (state != HS_HOLD);
    assign PSLVERR = PSEL & PENABLE & (PADDR != `IDWS_REG_CTRL)
        & (PADDR != `IDWS_REG_WORD) & (PADDR != `IDWS_REG_STATUS);

    // Read data is captured in the setup cycle.
    always_ff @(posedge CLK)
    begin
        if (!NRST)
            PRDATA <= 32'h0;
        else if (rd_setup)
        begin
            if (PADDR == `IDWS_REG_CTRL)
                PRDATA <= {27'h0, target_sel, rate, keep_open, 1'b0};
            else if (PADDR == `IDWS_REG_WORD)
                PRDATA <= {18'h0, word};
            else if (PADDR == `IDWS_REG_STATUS)
                PRDATA <= {29'h0, state == HS_HOLD, nack, busy};
            else
                PRDATA <= 32'h0;
        end
    end

    // Settings; a go while busy is dropped.
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            keep_open <= 1'b0;
            rate <= `IDWS_RATE_STD;
            target_sel <= 1'b0;
            word <= 14'h0;
            go <= 1'b0;
        end
        else
        begin
            go <= wr && PADDR == `IDWS_REG_CTRL && !busy
                && PWDATA[`IDWS_CTRL_GO];
            if (wr && PADDR == `IDWS_REG_CTRL && !busy)
            begin
                keep_open <= PWDATA[`IDWS_CTRL_KEEP];
                rate <= PWDATA[`IDWS_CTRL_RATE_LO+:2];
                target_sel <= PWDATA[`IDWS_CTRL_SEL];
            end
            if (wr && PADDR == `IDWS_REG_WORD && !busy)
                word <= PWDATA[13:0];
        end
    end

    // ==========================================================
    // Quarter-bit divider and SDA synchroniser
    // ==========================================================
    // High speed applies only after the master code.
    assign qlimit = (rate == `IDWS_RATE_HS && hs_active)
        ? `IDWS_QTR_W'(`IDWS_QTR_HS)
        : (rate == `IDWS_RATE_STD) ? `IDWS_QTR_W'(`IDWS_QTR_STD)
        : `IDWS_QTR_W'(`IDWS_QTR_FAST);
    assign tick = (qcnt == `IDWS_QTR_W'(0));

    always_ff @(posedge CLK)
    begin
        if (!NRST || !busy)
            qcnt <= `IDWS_QTR_W'(0);
        else if (tick)
            qcnt <= qlimit - `IDWS_QTR_W'(1);
        else
            qcnt <= qcnt - `IDWS_QTR_W'(1);
    end

    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end
        else
        begin
            sda_m <= LINK.sda;
            sda_s <= sda_m;
        end
    end

    // ==========================================================
    // Link sequencer
    // ==========================================================
    // Each bit is four quarters: set SDA with SCL low, raise SCL,
    // sample, lower SCL; SDA never moves while SCL is high.
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            state <= HS_IDLE;
            byte_idx <= HB_ADDR;
            phase <= 2'h0;
            bit_cnt <= 4'h0;
            tx <= 8'h00;
            nack <= 1'b0;
            hs_active <= 1'b0;
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
        end
        else if (go && state == HS_IDLE)
        begin
            state <= HS_START;
            phase <= 2'h0;
            nack <= 1'b0;
            byte_idx <= (rate == `IDWS_RATE_HS) ? HB_MCODE : HB_ADDR;
            tx <= byte_of((rate == `IDWS_RATE_HS) ? HB_MCODE : HB_ADDR,
                target_sel, word);
        end
        else if (go && state == HS_HOLD)
        begin
            state <= HS_BIT;
            byte_idx <= HB_HIGH;
            tx <= byte_of(HB_HIGH, target_sel, word);
            nack <= 1'b0;
        end
        else if (tick && busy)
        begin
            phase <= phase + 2'h1;
            case (state)
                HS_START:
                begin
                    if (phase == 2'h1)
                        sda_oe_n <= 1'b0;
                    if (phase == 2'h2)
                        scl_oe_n <= 1'b0;
                    if (phase == 2'h3)
                    begin
                        state <= HS_BIT;
                        bit_cnt <= 4'h0;
                    end
                end
                HS_RSTART:
                begin
                    if (phase == 2'h0)
                        sda_oe_n <= 1'b1;
                    if (phase == 2'h1)
                        scl_oe_n <= 1'b1;
                    if (phase == 2'h2)
                        sda_oe_n <= 1'b0;
                    if (phase == 2'h3)
                    begin
                        scl_oe_n <= 1'b0;
                        state <= HS_BIT;
                        bit_cnt <= 4'h0;
                    end
                end
                HS_STOP:
                begin
                    if (phase == 2'h0)
                        sda_oe_n <= 1'b0;
                    if (phase == 2'h1)
                        scl_oe_n <= 1'b1;
                    if (phase == 2'h2)
                        sda_oe_n <= 1'b1;
                    if (phase == 2'h3)
                    begin
                        state <= HS_IDLE;
                        hs_active <= 1'b0;
                    end
                end
                HS_BIT:
                begin
                    if (phase == 2'h0)
                        sda_oe_n <= (bit_cnt == `IDWS_ACK_BIT)
                            ? 1'b1 : tx[7];
                    if (phase == 2'h1)
                        scl_oe_n <= 1'b1;
                    if (phase == 2'h2 && bit_cnt != `IDWS_ACK_BIT)
                        tx <= {tx[6:0], 1'b0};
                    if (phase == 2'h3)
                    begin
                        scl_oe_n <= 1'b0;
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == `IDWS_ACK_BIT)
                        begin
                            bit_cnt <= 4'h0;
                            if (byte_idx == HB_MCODE)
                            begin
                                // Master code is never acked.
                                state <= HS_RSTART;
                                hs_active <= 1'b1;
                                byte_idx <= HB_ADDR;
                                tx <= byte_of(HB_ADDR, target_sel, word);
                            end
                            else if (sda_s)
                            begin
                                nack <= 1'b1;
                                state <= HS_STOP;
                            end
                            else if (byte_idx != HB_LOW)
                            begin
                                byte_idx <= (byte_idx == HB_ADDR)
                                    ? HB_HIGH : HB_LOW;
                                tx <= byte_of((byte_idx == HB_ADDR)
                                    ? HB_HIGH : HB_LOW, target_sel, word);
                            end
                            else
                                state <= keep_open ? HS_HOLD
                                    : HS_STOP;
                        end
                    end
                end
                default:
                begin
                    phase <= 2'h0;
                end
            endcase
        end
    end

    assign LINK.host_scl_o = 1'b0;
    assign LINK.host_sda_o = 1'b0;
    assign LINK.host_scl_oe_n = scl_oe_n;
    assign LINK.host_sda_oe_n = sda_oe_n;
endmodule : idws_host

// ==== rtl/idws_if.sv ====
`timescale 1ns/100ps
// ==========================================================
// Two-wire link between host and converter end
// ==========================================================
interface idws_if;
    logic host_scl_o;
    logic host_scl_oe_n;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic scl;
    logic sda;

    // Open-drain wires: released means pulled high.
    assign scl = host_scl_oe_n ? 1'b1 : host_scl_o;
    assign sda = (host_sda_oe_n ? 1'b1 : host_sda_o)
        & (dev_sda_oe_n ? 1'b1 : dev_sda_o);

    modport host (
        output host_scl_o,
        output host_scl_oe_n,
        output host_sda_o,
        output host_sda_oe_n,
        input scl,
        input sda
    );
    modport dev (
        output dev_sda_o,
        output dev_sda_oe_n,
        input scl,
        input sda
    );
endinterface : idws_if

// ==== rtl/idws_pkg.sv ====
package idws_pkg;
    // Device receive states.
    typedef enum logic [1:0] {
        DS_IDLE = 2'b00,
        DS_ADDR = 2'b01,
        DS_HIGH = 2'b10,
        DS_LOW = 2'b11
    } idws_dev_state_e;

    // Host link states.
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_START = 3'b001,
        HS_BIT = 3'b010,
        HS_RSTART = 3'b011,
        HS_STOP = 3'b100,
        HS_HOLD = 3'b101
    } idws_host_state_e;

    // Byte being sent by the host.
    typedef enum logic [1:0] {
        HB_MCODE = 2'b00,
        HB_ADDR = 2'b01,
        HB_HIGH = 2'b10,
        HB_LOW = 2'b11
    } idws_byte_e;
endpackage : idws_pkg

// ==== tb/idws_monitor.sv ====
`timescale 1ns/100ps
// ==========================================================
// Link checker on the wires between host and converter end
// ==========================================================
module idws_monitor (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic host_scl_o,
    input wire logic host_scl_oe_n,
    input wire logic host_sda_o,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    logic [9:0] ack_len;
    logic [9:0] high_len;

    // Run lengths saturate so a stuck line cannot wrap back to pass.
    always_ff @(posedge CLK)
    begin
        if (!NRST || dev_sda_oe_n)
            ack_len <= 10'h000;
        else if (ack_len != 10'h3ff)
            ack_len <= ack_len + 10'h001;
    end

    // Length of the current SCL high period.
    always_ff @(posedge CLK)
    begin
        if (!NRST || !scl)
            high_len <= 10'h000;
        else if (high_len != 10'h3ff)
            high_len <= high_len + 10'h001;
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    chk_rst_idle: assert property (
        $rose(NRST) |-> host_scl_oe_n && host_sda_oe_n && dev_sda_oe_n)
        else $error("lines not released after reset");
    chk_open_drain: assert property (
        !host_scl_o && !host_sda_o && !dev_sda_o)
        else $error("a line is driven high");
    chk_dev_stable: assert property (
        scl && $past(scl) |-> $stable(dev_sda_oe_n))
        else $error("device changed SDA while SCL high");
    chk_ack_low_scl: assert property (
        $fell(dev_sda_oe_n) |-> !scl)
        else $error("acknowledge started with SCL high");
    chk_ack_release: assert property (
        $fell(scl) && !dev_sda_oe_n |-> ##[1:6] dev_sda_oe_n)
        else $error("acknowledge not released after its clock");
    chk_ack_width: assert property (
        ack_len < 10'h1a0)
        else $error("device held SDA longer than one bit");
    chk_start_form: assert property (
        scl && $fell(sda) |-> scl [*2])
        else $error("start without SCL held high");
    chk_stop_idle: assert property (
        scl && $rose(sda) |-> (scl && sda) [*2])
        else $error("stop not followed by idle bus");
    chk_scl_high: assert property (
        $fell(scl) |-> $past(high_len) >= 10'h004)
        else $error("SCL high period too short");

    // Main link events.
    cover property ($fell(dev_sda_oe_n));
    cover property (scl && $fell(sda));
    cover property (scl && $rose(sda));
endmodule : idws_monitor

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
    fail_count++; $display("mismatch %s exp %h got %h", n, e, s); end end
// ==========================================================
// Bench: APB drives the host, the converter end is observed
// ==========================================================
module tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sel_pin = 1'b0;
    logic [11:0] code;
    logic [1:0] mode;
    logic upd;
    logic addressed;
    logic [31:0] stat;
    int fail_count = 0;
    int cmp_count = 0;
    int upd_cnt = 0;
    int cyc = 0;

    idws_if idws_if_i ();
    idws_host idws_host_i (.CLK(clk), .NRST(nrst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .LINK(idws_if_i.host));
    idws_dev idws_dev_i (.CLK(clk), .NRST(nrst), .LINK(idws_if_i.dev),
        .DEVICE_SELECT_PIN(sel_pin), .CONVERTER_CODE(code),
        .POWER_DOWN_MODE(mode), .CODE_UPDATED(upd),
        .ADDRESSED(addressed));
    idws_monitor idws_monitor_i (.CLK(clk), .NRST(nrst),
        .host_scl_o(idws_if_i.host_scl_o),
        .host_scl_oe_n(idws_if_i.host_scl_oe_n),
        .host_sda_o(idws_if_i.host_sda_o),
        .host_sda_oe_n(idws_if_i.host_sda_oe_n),
        .dev_sda_o(idws_if_i.dev_sda_o),
        .dev_sda_oe_n(idws_if_i.dev_sda_oe_n),
        .scl(idws_if_i.scl), .sda(idws_if_i.sda));

    // 40 MHz clock.
    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // Count update pulses; a missing or doubled pulse shows in the total.
    always @(posedge clk)
    begin
        cyc++;
        if (upd === 1'b1)
            upd_cnt++;
        if (cyc == 80000)
        begin
            fail_count++;
            final_report();
        end
    end

    // ======================================================
    // Bus tasks
    // ======================================================
    // One APB transfer, held until PREADY is seen at an edge.
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Load a word, start it, then poll until the host is no longer busy.
    task automatic xfer(input logic [11:0] c, input logic [1:0] m,
        input logic [1:0] rt, input logic s, input logic k);
        logic e;
        apb(1'b1, 8'h04, {18'h0, m, c}, stat, e);
        apb(1'b1, 8'h00, {27'h0, s, rt, k, 1'b1}, stat, e);
        repeat (4) @(posedge clk);
        stat = 32'h1;
        while (stat[0] === 1'b1)
            apb(1'b0, 8'h08, 32'h0, stat, e);
        repeat (4) @(posedge clk);
    endtask : xfer

    // Expected mode and code, rebuilt from the two bytes on the wire.
    function automatic logic [13:0] exp_word(input logic [1:0] m,
        input logic [11:0] c);
        logic [7:0] hi;
        logic [7:0] lo;
        hi = {2'b00, m, c[11:8]};
        lo = c[7:0];
        exp_word = {hi[5:4], hi[3:0], lo};
    endfunction : exp_word

    // Closing verdict.
    task automatic final_report();
        if (fail_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    // ======================================================
    // Main sequence
    // ======================================================
    initial
    begin
        logic [31:0] r;
        logic e;
        logic [11:0] c;
        logic [13:0] w;
        int exp_upd;
        r = $urandom(31);
        r = $urandom;
        sel_pin <= r[0];
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK("code_rst", 12'h000, code)
        `CHK("mode_rst", 2'h0, mode)
        apb(1'b0, 8'h08, 32'h0, r, e);
        `CHK("status_rst", 32'h0, r)
        apb(1'b0, 8'h0c, 32'h0, r, e);
        `CHK("unmapped_err", 1'b1, e)
        exp_upd = 0;
        // Every rate and every mode, with full and zero scale corners.
        for (int n = 0; n < 4; n++)
        begin
            r = $urandom;
            c = (n == 0) ? 12'hfff : (n == 1) ? 12'h000 : r[11:0];
            xfer(c, 2'(n), 2'(n % 3), sel_pin, 1'b0);
            exp_upd++;
            w = exp_word(2'(n), c);
            `CHK("nack", 1'b0, stat[1])
            `CHK("code", w[11:0], code)
            `CHK("mode", w[13:12], mode)
            `CHK("addressed_idle", 1'b0, addressed)
            `CHK("updates", exp_upd, upd_cnt)
        end
        // Other select bit: refused, converter keeps its last word.
        xfer(12'h5a5, 2'h1, 2'h2, ~sel_pin, 1'b0);
        `CHK("nack_sel", 1'b1, stat[1])
        `CHK("code_kept", c, code)
        `CHK("upd_kept", exp_upd, upd_cnt)
        `CHK("addressed_nack", 1'b0, addressed)
        // Two words in one transfer, the second without address.
        r = $urandom;
        xfer(r[11:0], 2'h2, 2'h1, sel_pin, 1'b1);
        `CHK("holding", 1'b1, stat[2])
        `CHK("addressed_hold", 1'b1, addressed)
        `CHK("code_w1", r[11:0], code)
        xfer(r[27:16], 2'h0, 2'h1, sel_pin, 1'b0);
        `CHK("code_w2", r[27:16], code)
        `CHK("mode_w2", 2'h0, mode)
        `CHK("upd_w2", exp_upd + 2, upd_cnt)
        `CHK("addressed_end", 1'b0, addressed)
        final_report();
    end
endmodule : tb_top
